/* File: psd_pkg.sv */
// shared constants for the host-to-pci sparse/dense memory bridge
package psd_pkg;
  // host address bus
  localparam int HADDR_W = 34;
  localparam int HADDR_LO = 5;
  localparam int SPACE_HI = 33;
  localparam int SPACE_LO = 32;
  localparam logic [1:0] SPACE_SPARSE = 2'h2;
  localparam logic [1:0] SPACE_DENSE = 2'h3;
  // sparse field positions
  localparam int SP_QW_HI = 31;
  localparam int SP_QW_LO = 8;
  localparam int SP_EXT_SEL_HI = 31;
  localparam int SP_EXT_SEL_LO = 29;
  localparam int SP_LW_SEL = 7;
  localparam int SP_LANE_HI = 6;
  localparam int SP_LANE_LO = 5;
  localparam int SP_LEN_HI = 4;
  localparam int SP_LEN_LO = 3;
  // dense field positions
  localparam int DN_LINE_HI = 31;
  localparam int DN_LINE_LO = 5;
  // pci side
  localparam int PCI_EXT_W = 5;
  localparam logic [4:0] FIXED_ZERO_EXTENSION = 5'h00;
  localparam int LW_W = 32;
  localparam int BE_W = 4;
  localparam int LINE_LW = 8;
  localparam int MASK_W = 8;
  localparam int QW_W = 64;
  localparam logic [3:0] BE_ALL_ON = 4'h0;
  localparam logic [3:0] BE_ALL_OFF = 4'hf;
  // length codes carried in host bits 4:3
  localparam logic [1:0] LEN_BYTE = 2'h0;
  localparam logic [1:0] LEN_WORD = 2'h1;
  localparam logic [1:0] LEN_TRIBYTE = 2'h2;
  localparam logic [1:0] LEN_LONG = 2'h3;
  localparam logic [1:0] LANE_QUAD = 2'h3;
  localparam logic [7:0] MASK_QUAD_WRITE = 8'hc0;
  localparam logic [7:0] MASK_PAIR_ONE = 8'h01;
endpackage

/* File: psd_host_if.sv */
// host processor bus between the host end and the bridge end
`timescale 1ns/10ps
`default_nettype none
interface psd_host_if;
  logic                                            req;
  logic                                            we;
  logic [psd_pkg::HADDR_W-1:psd_pkg::HADDR_LO]     addr;
  logic [psd_pkg::MASK_W-1:0]                      cwmask;
  logic [psd_pkg::LINE_LW*psd_pkg::LW_W-1:0]       wdata;
  logic                                            ack;
  logic [psd_pkg::QW_W-1:0]                        rdata;

  modport bridge (
    input  req,
    input  we,
    input  addr,
    input  cwmask,
    input  wdata,
    output ack,
    output rdata
  );
  modport host (
    output req,
    output we,
    output addr,
    output cwmask,
    output wdata,
    input  ack,
    input  rdata
  );
endinterface
`default_nettype wire

/* File: psd_sparse_lane_dec.sv */
// sparse space length/lane to active-low pci byte enable decoder
`timescale 1ns/10ps
`default_nettype none
module psd_sparse_lane_dec (
  input  wire logic [1:0] len_i,
  input  wire logic [1:0] lane_i,
  output logic [3:0]      be_n_o,
  output logic            quad_o,
  output logic            illegal_o
);
  logic [7:0] ones;
  logic [7:0] shifted;

  always_comb begin
    // len 0..3 selects 1..4 lanes starting at lane_i
    ones = 8'h0f >> (2'h3 - len_i);
    shifted = ones << lane_i;
    quad_o = (len_i == psd_pkg::LEN_LONG) && (lane_i == psd_pkg::LANE_QUAD);
    illegal_o = !quad_o && (|shifted[7:4]);
    if (quad_o) begin
      be_n_o = psd_pkg::BE_ALL_ON;
    end else begin
      // illegal combos still yield an enable pattern so the cycle completes
      be_n_o = ~shifted[3:0];
    end
  end
endmodule
`default_nettype wire

/* File: psd_host_end.sv */
// host processor end: builds longword masks and issues one access at a time
`timescale 1ns/10ps
`default_nettype none
module psd_host_end (
  input  wire logic                   clk_i,
  input  wire logic                   srst_i,
  psd_host_if.host                    bus,
  input  wire logic                   cmd_valid_i,
  input  wire logic                   cmd_write_i,
  input  wire logic [33:0]            cmd_addr_i,
  input  wire logic [7:0]             cmd_mask_i,
  input  wire logic [255:0]           cmd_wdata_i,
  output logic                        cmd_busy_o,
  output logic                        rsp_valid_o,
  output logic [63:0]                 rsp_data_o
);
  logic sub_read_q;

  function automatic logic [7:0] build_mask(input logic we, input logic [33:0] a,
                                            input logic [7:0] m);
    logic [1:0] sp;
    logic [1:0] len;
    sp = a[psd_pkg::SPACE_HI:psd_pkg::SPACE_LO];
    len = a[psd_pkg::SP_LEN_HI:psd_pkg::SP_LEN_LO];
    if (!we) begin
      build_mask = {6'h00, len};
    end else if (sp == psd_pkg::SPACE_DENSE) begin
      build_mask = m;
    end else if ({a[psd_pkg::SP_LANE_HI:psd_pkg::SP_LANE_LO], len} == 4'hf) begin
      build_mask = psd_pkg::MASK_QUAD_WRITE;
    end else begin
      build_mask = psd_pkg::MASK_PAIR_ONE << {len, 1'b0};
    end
  endfunction

  // one access outstanding until its ack acts as the barrier between writes
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      bus.req <= 1'b0;
      bus.we <= 1'b0;
      bus.addr <= '0;
      bus.cwmask <= 8'h00;
      bus.wdata <= '0;
      cmd_busy_o <= 1'b0;
      sub_read_q <= 1'b0;
    end else if (!cmd_busy_o && cmd_valid_i) begin
      bus.req <= 1'b1;
      bus.we <= cmd_write_i;
      bus.addr <= cmd_addr_i[psd_pkg::HADDR_W-1:psd_pkg::HADDR_LO];
      bus.cwmask <= build_mask(cmd_write_i, cmd_addr_i, cmd_mask_i);
      bus.wdata <= cmd_wdata_i;
      cmd_busy_o <= 1'b1;
      sub_read_q <= !cmd_write_i
                    && cmd_addr_i[psd_pkg::SPACE_HI:psd_pkg::SPACE_LO] == psd_pkg::SPACE_SPARSE
                    && cmd_addr_i[psd_pkg::SP_LANE_HI:psd_pkg::SP_LEN_LO] != 4'hf;
    end else if (bus.ack) begin
      bus.req <= 1'b0;
      cmd_busy_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 64'h0;
    end else begin
      rsp_valid_o <= bus.ack && cmd_busy_o;
      if (bus.ack && cmd_busy_o) begin
        // sub-quadword loads use the lower longword only
        rsp_data_o <= sub_read_q ? {32'h0, bus.rdata[31:0]} : bus.rdata;
      end
    end
  end
endmodule
`default_nettype wire

/* File: psd_bridge.sv */
// bridge end: host sparse/dense memory access to pci memory bursts
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - bits 33:32 select sparse or dense memory
// - sparse host 31:8 drives pci 26:3
// - sparse 4GB host covers 128MB pci
// - pci 31:27 zero or from extension
// - bits 4:3 length, 6:5 lane, enables
// - byte enables active low
// - pci bit 2 from host 7, quad 000
// - illegal sparse combos still complete
// - reads take bits 4:3 from mask
// - sparse writes derive 4:3 from mask pairs
// - host: quadword max, barrier after writes
// - host: sub-quad write mask single 01 pair
// - host: quad write mask is 11000000
// - host: proper load forms per size
// - dense host 31:5 maps to pci 31:5
// - host: dense minimum is a longword
// - dense reads are two longword bursts
// - dense writes burst up to eight longwords
// - any dense mask, holes sent disabled
// - targets accept all-disabled data phases
// - dense read prefetch is allowed
module psd_bridge (
  input  wire logic                   clk_i,
  input  wire logic                   srst_i,
  psd_host_if.bridge                  host,
  input  wire logic [4:0]             mem_high_extension_reg_i,
  output logic                        pci_req_o,
  output logic                        pci_write_o,
  output logic [31:0]                 pci_addr_o,
  output logic [3:0]                  pci_be_n_o,
  output logic [31:0]                 pci_wdata_o,
  output logic                        pci_last_o,
  input  wire logic                   pci_ready_i,
  input  wire logic [31:0]            pci_rdata_i
);
  typedef enum {ST_IDLE, ST_BURST, ST_ACK} psd_brg_state_e;

  psd_brg_state_e state_q;
  logic [2:0]     beat_q;
  logic [2:0]     last_beat_q;
  logic [31:0]    be8_q;
  logic [255:0]   wd_q;
  logic [63:0]    rd_q;
  logic [63:0]    rd_nxt;

  logic [1:0]     space;
  logic [1:0]     len;
  logic [1:0]     lane;
  logic [3:0]     sp_be_n;
  logic           sp_quad;
  logic [4:0]     ext;
  logic [2:0]     first_lw;
  logic [2:0]     last_lw;
  logic           go_d;
  logic [31:0]    addr_d;
  logic [31:0]    be8_d;
  logic [2:0]     first_d;
  logic [2:0]     last_d;
  logic [2:0]     beat_inc;

  // sparse write length: highest nonzero mask pair wins so 11000000 means quad
  function automatic logic [1:0] write_len(input logic [7:0] m);
    logic [1:0] l;
    l = psd_pkg::LEN_BYTE;
    if (|m[7:6]) begin
      l = psd_pkg::LEN_LONG;
    end else if (|m[5:4]) begin
      l = psd_pkg::LEN_TRIBYTE;
    end else if (|m[3:2]) begin
      l = psd_pkg::LEN_WORD;
    end
    return l;
  endfunction

  function automatic logic [2:0] lowest_set(input logic [7:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) begin
        r = i[2:0];
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] highest_set(input logic [7:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (m[i]) begin
        r = i[2:0];
      end
    end
    return r;
  endfunction

  psd_sparse_lane_dec u_lane_dec (
    .len_i     (len),
    .lane_i    (lane),
    .be_n_o    (sp_be_n),
    .quad_o    (sp_quad),
    .illegal_o ()
  );

  always_comb begin
    space = host.addr[psd_pkg::SPACE_HI:psd_pkg::SPACE_LO];
    // host bits 4:3 never travel as address; they live in the mask
    len = host.we ? write_len(host.cwmask) : host.cwmask[1:0];
    lane = host.addr[psd_pkg::SP_LANE_HI:psd_pkg::SP_LANE_LO];
    // lower 16MB of sparse space is pinned to pci zero
    if (host.addr[psd_pkg::SP_EXT_SEL_HI:psd_pkg::SP_EXT_SEL_LO] == 3'h0) begin
      ext = psd_pkg::FIXED_ZERO_EXTENSION;
    end else begin
      ext = mem_high_extension_reg_i;
    end
    first_lw = lowest_set(host.cwmask);
    last_lw = highest_set(host.cwmask);
    go_d = 1'b0;
    addr_d = 32'h0;
    be8_d = {8{psd_pkg::BE_ALL_OFF}};
    first_d = 3'h0;
    last_d = 3'h0;
    if (space == psd_pkg::SPACE_SPARSE) begin
      go_d = 1'b1;
      // 24 quadword bits plus 5 extension bits: 4GB of host in 128MB of pci
      addr_d = {ext, host.addr[psd_pkg::SP_QW_HI:psd_pkg::SP_QW_LO],
                sp_quad ? 3'h0 : {host.addr[psd_pkg::SP_LW_SEL], 2'h0}};
      be8_d[3:0] = sp_be_n;
      if (sp_quad) begin
        be8_d[7:4] = psd_pkg::BE_ALL_ON;
        last_d = 3'h1;
      end
    end else if (space == psd_pkg::SPACE_DENSE) begin
      if (!host.we) begin
        // whole quadword fetched; extra longword has no side effects
        go_d = 1'b1;
        addr_d = {host.addr[psd_pkg::DN_LINE_HI:psd_pkg::DN_LINE_LO],
                  host.cwmask[1:0], 3'h0};
        be8_d[7:0] = {psd_pkg::BE_ALL_ON, psd_pkg::BE_ALL_ON};
        last_d = 3'h1;
      end else begin
        go_d = |host.cwmask;
        addr_d = {host.addr[psd_pkg::DN_LINE_HI:psd_pkg::DN_LINE_LO],
                  first_lw, 2'h0};
        for (int i = 0; i < psd_pkg::LINE_LW; i++) begin
          // holes between first and last still get a data phase, disabled
          be8_d[i*4 +: 4] = host.cwmask[i] ? psd_pkg::BE_ALL_ON
                                           : psd_pkg::BE_ALL_OFF;
        end
        first_d = first_lw;
        last_d = last_lw;
      end
    end
  end

  always_comb begin
    beat_inc = beat_q + 3'h1;
    rd_nxt = rd_q;
    rd_nxt[beat_q[0]*32 +: 32] = pci_rdata_i;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= ST_IDLE;
      host.ack <= 1'b0;
      pci_req_o <= 1'b0;
      pci_write_o <= 1'b0;
      pci_addr_o <= 32'h0;
      pci_be_n_o <= psd_pkg::BE_ALL_OFF;
      pci_wdata_o <= 32'h0;
      pci_last_o <= 1'b0;
      beat_q <= 3'h0;
      last_beat_q <= 3'h0;
      be8_q <= 32'hffffffff;
      wd_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (host.req && go_d) begin
            state_q <= ST_BURST;
            pci_req_o <= 1'b1;
            pci_write_o <= host.we;
            pci_addr_o <= addr_d;
            pci_be_n_o <= be8_d[first_d*4 +: 4];
            pci_wdata_o <= host.wdata[first_d*32 +: 32];
            pci_last_o <= (first_d == last_d);
            beat_q <= first_d;
            last_beat_q <= last_d;
            be8_q <= be8_d;
            wd_q <= host.wdata;
          end else if (host.req) begin
            // other spaces and dense writes with empty masks complete with no pci cycle
            state_q <= ST_ACK;
            host.ack <= 1'b1;
          end
        end
        ST_BURST: begin
          if (pci_ready_i) begin
            if (pci_last_o) begin
              state_q <= ST_ACK;
              host.ack <= 1'b1;
              pci_req_o <= 1'b0;
              pci_last_o <= 1'b0;
              pci_be_n_o <= psd_pkg::BE_ALL_OFF;
            end else begin
              beat_q <= beat_inc;
              pci_be_n_o <= be8_q[beat_inc*4 +: 4];
              pci_wdata_o <= wd_q[beat_inc*32 +: 32];
              pci_last_o <= (beat_inc == last_beat_q);
            end
          end
        end
        ST_ACK: begin
          // host drops req on the edge that sees ack
          state_q <= ST_IDLE;
          host.ack <= 1'b0;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_q <= 64'h0;
      host.rdata <= 64'h0;
    end else if (state_q == ST_IDLE && host.req) begin
      rd_q <= 64'h0;
    end else if (state_q == ST_BURST && pci_ready_i && !pci_write_o) begin
      rd_q <= rd_nxt;
      if (pci_last_o) begin
        host.rdata <= rd_nxt;
      end
    end
  end
endmodule
`default_nettype wire

/* File: psd_checker.sv */
// concurrent checks on the host bus and pci side of the bridge
`timescale 1ns/10ps
`default_nettype none
module psd_checker (
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic        req,
  input wire logic        we,
  input wire logic [33:5] addr,
  input wire logic [7:0]  cwmask,
  input wire logic        ack,
  input wire logic        pci_req_o,
  input wire logic        pci_write_o,
  input wire logic [31:0] pci_addr_o,
  input wire logic [3:0]  pci_be_n_o,
  input wire logic        pci_last_o,
  input wire logic        pci_ready_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // host address holds through the pci cycle, so it can be compared directly
  wire logic sp = pci_req_o && req && addr[33:32] == 2'h2;
  wire logic dn = pci_req_o && req && addr[33:32] == 2'h3;

  a_sparse_qw_addr: assert property (sp |-> pci_addr_o[26:3] == addr[31:8])
    else $error("sparse quadword address wrong");
  a_sparse_ext_zero: assert property (sp && addr[31:29] == 3'h0 |-> pci_addr_o[31:27] == 5'h00)
    else $error("sparse low region not at zero");
  // lane 3 is either a byte or a quadword, which differ in bit 2
  a_sparse_low_bits: assert property (sp && addr[6:5] != 2'h3 |-> pci_addr_o[2:0] == {addr[7], 2'h0})
    else $error("sparse low address bits wrong");
  a_dense_addr_map: assert property (dn |-> pci_addr_o[31:5] == addr[31:5])
    else $error("dense address not one to one");
  a_dense_read_low: assert property (dn && !we |-> pci_addr_o[4:0] == {cwmask[1:0], 3'h0})
    else $error("dense read low address wrong");
  a_dense_read_burst: assert property ($rose(pci_req_o) && !pci_write_o && addr[33:32] == 2'h3
    |-> !pci_last_o ##1 pci_req_o)
    else $error("dense read not a two phase burst");
  a_idle_be_off: assert property (!pci_req_o |-> pci_be_n_o == 4'hf)
    else $error("byte enables active while idle");
  a_ack_after_last: assert property (pci_req_o && pci_ready_i && pci_last_o |=> ack && !pci_req_o)
    else $error("no completion after last phase");
  a_ack_single: assert property (ack |=> !ack)
    else $error("completion longer than one cycle");
  a_access_bounded: assert property ($rose(req) |-> ##[1:60] ack)
    else $error("access never completed");
endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking bench joining the host end and the bridge end
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic         clk_i = 1'b0;
  logic         srst_i = 1'b1;
  logic         cmd_valid_i = 1'b0;
  logic         cmd_write_i = 1'b0;
  logic [33:0]  cmd_addr_i = '0;
  logic [7:0]   cmd_mask_i = '0;
  logic [255:0] cmd_wdata_i;
  logic [4:0]   ext_q = 5'h15;
  logic         pci_ready_i = 1'b0;
  logic [31:0]  pci_rdata_i = '0;
  logic         slow = 1'b0;
  logic         cmd_busy_o, rsp_valid_o, pci_req_o, pci_write_o, pci_last_o;
  logic [63:0]  rsp_data_o;
  logic [31:0]  pci_addr_o, pci_wdata_o, ph_addr;
  logic [3:0]   pci_be_n_o;
  logic         ph_we = 1'b0;
  int           nlast = 0;
  logic [3:0]   ph_be [8];
  logic [31:0]  ph_wd [8];
  int           nph = 0;
  int           err_total = 0;
  int           cmp_count = 0;

  psd_host_if u_psd_host_if ();
  psd_host_end u_psd_host_end (.clk_i, .srst_i, .bus(u_psd_host_if), .cmd_valid_i, .cmd_write_i,
    .cmd_addr_i, .cmd_mask_i, .cmd_wdata_i, .cmd_busy_o, .rsp_valid_o, .rsp_data_o);
  psd_bridge u_psd_bridge (.clk_i, .srst_i, .host(u_psd_host_if), .mem_high_extension_reg_i(ext_q),
    .pci_req_o, .pci_write_o, .pci_addr_o, .pci_be_n_o, .pci_wdata_o, .pci_last_o, .pci_ready_i,
    .pci_rdata_i);
  psd_checker u_psd_checker (.clk_i, .srst_i, .req(u_psd_host_if.req), .we(u_psd_host_if.we),
    .addr(u_psd_host_if.addr), .cwmask(u_psd_host_if.cwmask), .ack(u_psd_host_if.ack), .pci_req_o,
    .pci_write_o, .pci_addr_o, .pci_be_n_o, .pci_last_o, .pci_ready_i);

  always #10 clk_i = ~clk_i;

  // target: every phase is logged; slow mode stalls every other cycle
  always @(posedge clk_i) begin
    pci_ready_i <= slow ? !pci_ready_i : 1'b1;
    if (pci_req_o && pci_ready_i) begin
      ph_be[nph[2:0]] <= pci_be_n_o;
      ph_wd[nph[2:0]] <= pci_wdata_o;
      ph_addr <= pci_addr_o;
      ph_we <= pci_write_o;
      nlast <= nlast + int'(pci_last_o);
      nph <= nph + 1;
      pci_rdata_i <= 32'ha5000001 + nph;
    end
  end

  task automatic ck(input string nm, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic op(input logic w, input logic [33:0] a, input logic [7:0] m);
    int t;
    @(posedge clk_i);
    nph <= 0;
    nlast <= 0;
    pci_rdata_i <= 32'ha5000000;
    cmd_valid_i <= 1'b1;
    cmd_write_i <= w;
    cmd_addr_i <= a;
    cmd_mask_i <= m;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    @(posedge clk_i);
    ck("busy", 64'h1, {63'h0, cmd_busy_o});
    for (t = 0; t < 80 && rsp_valid_o !== 1'b1; t++) @(posedge clk_i);
    ck("done", 64'h1, {63'h0, rsp_valid_o});
    ck("idle", 64'h0, {63'h0, cmd_busy_o});
    ck("last flags", nph != 0, nlast);
    if (nph != 0) ck("pci write", w, ph_we);
  endtask

  // index is {length, lane}; f marks combinations left out here
  task automatic t_sparse_lanes();
    logic [3:0] be_tab [16] = '{4'he, 4'hd, 4'hb, 4'h7, 4'hc, 4'h9, 4'h3, 4'hf,
                                4'h8, 4'h1, 4'hf, 4'hf, 4'h0, 4'hf, 4'hf, 4'hf};
    logic [33:0] a;
    for (int i = 0; i < 13; i++) begin
      if (be_tab[i] != 4'hf) begin
        a = {2'h2, 3'h0, 21'h12345, ~i[0], i[1:0], i[3:2], 3'h0};
        op(i[0], a, 8'h00);
        ck("sparse addr", {5'h0, a[31:8], a[7], 2'h0}, ph_addr);
        ck("sparse be", be_tab[i], ph_be[0]);
        ck("sparse phases", 1, nph);
        if (i[0]) ck("sparse wdata", 32'hd0000000, ph_wd[0]);
        else ck("sparse rdata", 64'ha5000000, rsp_data_o);
      end
    end
  endtask

  task automatic t_sparse_quad();
    logic [33:0] a;
    a = {2'h2, 3'h5, 21'h0abcd, 1'b1, 2'h3, 2'h3, 3'h0};
    slow <= 1'b1;
    op(1'b0, a, 8'h00);
    ck("quad addr", {ext_q, a[31:8], 3'h0}, ph_addr);
    ck("quad phases", 2, nph);
    ck("quad rdata", 64'ha5000001a5000000, rsp_data_o);
    op(1'b1, a, 8'h00);
    ck("quad be", 4'h0, ph_be[1]);
    ck("quad wdata", 32'hd0000001, ph_wd[1]);
    slow <= 1'b0;
  endtask

  // other spaces and dense writes with empty masks finish with no pci cycle; illegal sparse still runs
  task automatic t_no_cycle();
    op(1'b0, {2'h1, 32'h0}, 8'h00);
    ck("other space phases", 0, nph);
    op(1'b1, {2'h3, 32'h0}, 8'h00);
    ck("empty dense phases", 0, nph);
    op(1'b1, {2'h2, 24'h0, 1'b0, 2'h3, 2'h1, 3'h0}, 8'h00);
    ck("illegal phases", 1, nph);
  endtask

  task automatic t_dense_read();
    logic [33:0] a;
    a = {2'h3, 27'h5a5a5a5, 2'h2, 3'h0};
    op(1'b0, a, 8'h00);
    ck("dense rd addr", {a[31:5], 2'h2, 3'h0}, ph_addr);
    ck("dense rd phases", 2, nph);
    ck("dense rd be", 4'h0, ph_be[1]);
    ck("dense rdata", 64'ha5000001a5000000, rsp_data_o);
  endtask

  // holes inside the burst must still be sent, with every lane off
  task automatic t_dense_write();
    logic [7:0] ms [4] = '{8'ha6, 8'h80, 8'hff, 8'h0c};
    int lo, hi;
    logic [33:0] a;
    a = {2'h3, 27'h1234567, 5'h0};
    foreach (ms[j]) begin
      lo = 8;
      hi = 0;
      for (int k = 7; k >= 0; k--) if (ms[j][k]) lo = k;
      for (int k = 0; k < 8; k++) if (ms[j][k]) hi = k;
      op(1'b1, a, ms[j]);
      ck("dense addr", {a[31:5], 3'(lo), 2'h0}, ph_addr);
      ck("dense phases", hi - lo + 1, nph);
      for (int k = lo; k <= hi; k++) begin
        ck("dense be", ms[j][k] ? 4'h0 : 4'hf, ph_be[k-lo]);
        if (ms[j][k]) ck("dense wdata", 32'hd0000000 + k, ph_wd[k-lo]);
      end
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 8; i++) cmd_wdata_i[32*i +: 32] = 32'hd0000000 + i;
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    t_sparse_lanes();
    t_sparse_quad();
    t_dense_read();
    t_dense_write();
    t_no_cycle();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    conclude();
  end
endmodule
`default_nettype wire
